// ==== verilog/acis_pkg.sv ====
/*
  Package for the auxiliary channel input select block: register offsets,
  field positions, reset value, variant codes and mux carrier struct.
  Assumes a 32-bit AXI4-Lite register bus with byte addressing.
*/
`default_nettype none
package acis_pkg;

  // Register map.
  localparam logic [7:0]  SEL_OFFSET     = 8'h00;
  localparam logic [7:0]  VARIANT_OFFSET = 8'h04;
  localparam logic [15:0] SEL_RESET      = 16'h0000;
  localparam logic [15:0] SEL_WMASK      = 16'h0707;

  // Field positions inside the select register.
  localparam int SB_NEG_HI = 10;
  localparam int SB_NEG_LO = 9;
  localparam int SB_POS    = 8;
  localparam int SA_NEG_HI = 2;
  localparam int SA_NEG_LO = 1;
  localparam int SA_POS    = 0;

  // AXI responses.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Device variants, given as a two-bit strap.
  typedef enum logic [1:0] {
    VAR_SMALL_MEM = 2'h0,
    VAR_LARGE_MEM = 2'h1,
    VAR_LARGE_PIN = 2'h2
  } acis_variant_e;

  // Analog input codes seen by a channel mux.
  localparam logic [3:0] AIN_NONE = 4'hf;
  localparam logic [3:0] AIN_GND  = 4'he;

  // One channel's negative and positive mux selections.
  typedef struct packed {
    logic [3:0] neg;
    logic [3:0] pos;
  } acis_chan_s;

  typedef struct packed {
    acis_chan_s ch3;
    acis_chan_s ch2;
    acis_chan_s ch1;
  } acis_mux_s;

endpackage : acis_pkg
`default_nettype wire

// ==== verilog/acis_decode.sv ====
/*
  Combinational decoder from one sample's select fields to the analog mux
  codes of channels 1 to 3. Assumes the variant input is stable.
*/
`default_nettype none
`timescale 1ns/10ps
module acis_decode
(
  // Field values
  input  wire logic [1:0]       neg_sel,
  input  wire logic             pos_sel,
  // Device variant
  input  wire logic [1:0]       variant,
  // Mux codes
  output acis_pkg::acis_mux_s   mux
);

  always_comb
  begin
    mux = '{default: '0};
    // Positive inputs.
    if (!pos_sel)
    begin
      mux.ch1.pos = 4'h0;
      mux.ch2.pos = 4'h1;
      mux.ch3.pos = 4'h2;
    end
    else if (variant == acis_pkg::VAR_SMALL_MEM)
    begin
      mux.ch1.pos = 4'h3;
      mux.ch2.pos = acis_pkg::AIN_NONE;
      mux.ch3.pos = acis_pkg::AIN_NONE;
    end
    else
    begin
      mux.ch1.pos = 4'h3;
      mux.ch2.pos = 4'h4;
      mux.ch3.pos = 4'h5;
    end
    // Negative inputs default to ground; reserved codes also ground.
    mux.ch1.neg = acis_pkg::AIN_GND;
    mux.ch2.neg = acis_pkg::AIN_GND;
    mux.ch3.neg = acis_pkg::AIN_GND;
    case (variant)
      acis_pkg::VAR_LARGE_MEM:
      begin
        if (neg_sel == 2'h3)
        begin
          mux.ch1.neg = 4'h9;
          mux.ch2.neg = 4'ha;
          mux.ch3.neg = acis_pkg::AIN_NONE;
        end
      end
      acis_pkg::VAR_LARGE_PIN:
      begin
        if (neg_sel == 2'h3)
        begin
          mux.ch1.neg = 4'h9;
          mux.ch2.neg = 4'ha;
          mux.ch3.neg = 4'hb;
        end
        else if (neg_sel == 2'h2)
        begin
          mux.ch1.neg = 4'h6;
          mux.ch2.neg = 4'h7;
          mux.ch3.neg = 4'h8;
        end
      end
      default:
      begin
        mux.ch1.neg = acis_pkg::AIN_GND;
      end
    endcase
  end

endmodule : acis_decode
`default_nettype wire

// ==== verilog/acis_top.sv ====
/*
  Auxiliary channel input select register with AXI4-Lite slave and the
  analog mux controls for channels 1 to 3, sample A and sample B.
  Assumes one clock, a synchronous reset and a variant strap that is
  stable while reset is released.
*/
// Our own choices: the register addresses and the AXI4-Lite register port.
`default_nettype none
`timescale 1ns/10ps
module acis_top
(
  // Clock and reset
  input  wire logic           clk,
  input  wire logic           rst,
  // Variant strap and sequencing
  input  wire logic [1:0]     variant_strap,
  input  wire logic           samp_b_active,
  // AXI4-Lite write address
  input  wire logic [7:0]     s_axi_awaddr,
  input  wire logic           s_axi_awvalid,
  output logic                s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]    s_axi_wdata,
  input  wire logic [3:0]     s_axi_wstrb,
  input  wire logic           s_axi_wvalid,
  output logic                s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]          s_axi_bresp,
  output logic                s_axi_bvalid,
  input  wire logic           s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [7:0]     s_axi_araddr,
  input  wire logic           s_axi_arvalid,
  output logic                s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]         s_axi_rdata,
  output logic [1:0]          s_axi_rresp,
  output logic                s_axi_rvalid,
  input  wire logic           s_axi_rready,
  // Analog mux controls
  output acis_pkg::acis_mux_s mux_ctrl
);

  logic [15:0]         sel_q;
  logic [1:0]          variant_q;
  logic                aw_held_q;
  logic [7:0]          awaddr_q;
  logic                w_held_q;
  logic [31:0]         wdata_q;
  logic [3:0]          wstrb_q;
  logic                wr_go;
  logic                rd_go;
  logic [31:0]         rd_word;
  logic                rd_hit;
  logic                wr_hit;
  logic                samp_b_m1_q;
  logic                samp_b_m2_q;
  logic                samp_b_m3_q;
  logic                samp_b_q;
  acis_pkg::acis_mux_s mux_a;
  acis_pkg::acis_mux_s mux_b;

  // The strap is caught on clock edges under reset, never asynchronously.
  always_ff @(posedge clk)
  begin
    if (rst)
      variant_q <= variant_strap;
  end

  // Write channels are accepted independently, held until both are present.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      aw_held_q <= 1'b0;
      awaddr_q  <= 8'h00;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held_q <= 1'b1;
      awaddr_q  <= s_axi_awaddr;
    end
    else if (wr_go)
      aw_held_q <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      w_held_q <= 1'b0;
      wdata_q  <= 32'h00000000;
      wstrb_q  <= 4'h0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_held_q <= 1'b1;
      wdata_q  <= s_axi_wdata;
      wstrb_q  <= s_axi_wstrb;
    end
    else if (wr_go)
      w_held_q <= 1'b0;
  end

  // Readies are flops so that every port leaves a register. Each one
  // reopens only once its channel is free and no response is pending,
  // which costs two idle cycles between writes but never drops a beat.
  always_ff @(posedge clk)
  begin
    if (rst)
      s_axi_awready <= 1'b0;
    else if (s_axi_awvalid && s_axi_awready)
      s_axi_awready <= 1'b0;
    else if (!aw_held_q && (!s_axi_bvalid || s_axi_bready))
      s_axi_awready <= 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      s_axi_wready <= 1'b0;
    else if (s_axi_wvalid && s_axi_wready)
      s_axi_wready <= 1'b0;
    else if (!w_held_q && (!s_axi_bvalid || s_axi_bready))
      s_axi_wready <= 1'b1;
  end

  assign wr_go  = aw_held_q && w_held_q && !s_axi_bvalid;
  assign wr_hit = awaddr_q[7:2] == acis_pkg::SEL_OFFSET[7:2];

  // Only the select word is writable; unimplemented bits never store.
  always_ff @(posedge clk)
  begin
    if (rst)
      sel_q <= acis_pkg::SEL_RESET;
    else if (wr_go && wr_hit)
    begin
      if (wstrb_q[0])
        sel_q[7:0] <= wdata_q[7:0] & acis_pkg::SEL_WMASK[7:0];
      if (wstrb_q[1])
        sel_q[15:8] <= wdata_q[15:8] & acis_pkg::SEL_WMASK[15:8];
    end
  end

  // Write response; an unmapped or read-only address answers SLVERR.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= acis_pkg::RESP_OKAY;
    end
    else if (wr_go)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? acis_pkg::RESP_OKAY : acis_pkg::RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // Read path: one request at a time, answered one cycle after acceptance.
  always_ff @(posedge clk)
  begin
    if (rst)
      s_axi_arready <= 1'b0;
    else if (rd_go)
      s_axi_arready <= 1'b0;
    else if (!s_axi_rvalid || s_axi_rready)
      s_axi_arready <= 1'b1;
  end

  assign rd_go = s_axi_arvalid && s_axi_arready;

  always_comb
  begin
    rd_word = 32'h00000000;
    rd_hit  = 1'b1;
    case (s_axi_araddr[7:2])
      acis_pkg::SEL_OFFSET[7:2]:
        rd_word = {16'h0000, sel_q & acis_pkg::SEL_WMASK};
      acis_pkg::VARIANT_OFFSET[7:2]:
        rd_word = {30'h00000000, variant_q};
      default:
        rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= acis_pkg::RESP_OKAY;
    end
    else if (rd_go)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_hit ? acis_pkg::RESP_OKAY : acis_pkg::RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // The sequencing request may come from another domain, so it passes
  // three flops and changes once the last two agree.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      samp_b_m1_q <= 1'b0;
      samp_b_m2_q <= 1'b0;
      samp_b_m3_q <= 1'b0;
      samp_b_q    <= 1'b0;
    end
    else
    begin
      samp_b_m1_q <= samp_b_active;
      samp_b_m2_q <= samp_b_m1_q;
      samp_b_m3_q <= samp_b_m2_q;
      if (samp_b_m2_q == samp_b_m3_q)
        samp_b_q <= samp_b_m3_q;
    end
  end

  acis_decode u_dec_a
  (
    .neg_sel (sel_q[acis_pkg::SA_NEG_HI:acis_pkg::SA_NEG_LO]),
    .pos_sel (sel_q[acis_pkg::SA_POS]),
    .variant (variant_q),
    .mux     (mux_a)
  );

  acis_decode u_dec_b
  (
    .neg_sel (sel_q[acis_pkg::SB_NEG_HI:acis_pkg::SB_NEG_LO]),
    .pos_sel (sel_q[acis_pkg::SB_POS]),
    .variant (variant_q),
    .mux     (mux_b)
  );

  // Registering the mux code keeps analog switch controls glitch free.
  always_ff @(posedge clk)
  begin
    if (rst)
      mux_ctrl <= mux_a;
    else
      mux_ctrl <= samp_b_q ? mux_b : mux_a;
  end

endmodule : acis_top
`default_nettype wire

// ==== verification/acis_mux_model.sv ====
/*
  Model of the analog input multiplexers of channels 1 to 3.
  Assumes the mux codes change only at the rising clock edge.
*/
`timescale 1ns/10ps
`default_nettype none
module acis_mux_model
(
  // Clock
  input  wire logic                clk,
  // Mux selections
  input  wire acis_pkg::acis_mux_s mux,
  // Code 12 or 13 seen: no such input exists
  output var logic                 bad
);
  initial bad = 1'b0;
  always @(posedge clk)
    for (int c = 0; c < 6; c++)
      if (mux[c*4 +: 4] inside {4'hc, 4'hd})
        bad <= 1'b1;
endmodule : acis_mux_model
`default_nettype wire

// ==== verification/acis_assertions.sv ====
/*
  Checks on the ports of acis_top: mux codes against the variant strap,
  reset state and read data. Assumes the strap only moves in reset.
*/
`timescale 1ns/10ps
`default_nettype none
module acis_assertions
(
  // Clock, reset and strap
  input wire logic                clk,
  input wire logic                rst,
  input wire logic [1:0]          variant_strap,
  // Read data
  input wire logic                s_axi_rvalid,
  input wire logic [31:0]         s_axi_rdata,
  // Mux controls
  input wire acis_pkg::acis_mux_s mux_ctrl
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire logic [1:0] v = variant_strap;
  wire acis_pkg::acis_chan_s c1 = mux_ctrl.ch1;
  wire acis_pkg::acis_chan_s c2 = mux_ctrl.ch2;
  wire acis_pkg::acis_chan_s c3 = mux_ctrl.ch3;
  property p_rst_mux;
    $fell(rst) |-> mux_ctrl == 24'he2e1e0;
  endproperty
  a_rst_mux: assert property (p_rst_mux)
    else $error("mux not at reset decode");
  property p_pos0;
    c1.pos == 4'h0 |-> c2.pos == 4'h1 && c3.pos == 4'h2;
  endproperty
  a_pos0: assert property (p_pos0)
    else $error("bad positive set 0");
  property p_pos_small;
    v == 2'h0 && c1.pos == 4'h3 |-> c2.pos == 4'hf && c3.pos == 4'hf;
  endproperty
  a_pos_small: assert property (p_pos_small)
    else $error("bad positive set 1, small");
  property p_pos_big;
    v != 2'h0 && c1.pos == 4'h3 |-> c2.pos == 4'h4 && c3.pos == 4'h5;
  endproperty
  a_pos_big: assert property (p_pos_big)
    else $error("bad positive set 1");
  property p_neg_small;
    v == 2'h0 |-> {c1.neg, c2.neg, c3.neg} == 12'heee;
  endproperty
  a_neg_small: assert property (p_neg_small)
    else $error("negative not grounded");
  property p_neg_lm;
    v == 2'h1 && c1.neg == 4'h9 |-> c2.neg == 4'ha && c3.neg == 4'hf;
  endproperty
  a_neg_lm: assert property (p_neg_lm)
    else $error("bad negative set 3, large memory");
  property p_neg_lp11;
    v == 2'h2 && c1.neg == 4'h9 |-> c2.neg == 4'ha && c3.neg == 4'hb;
  endproperty
  a_neg_lp11: assert property (p_neg_lp11)
    else $error("bad negative set 3");
  property p_neg_lp10;
    v == 2'h2 && c1.neg == 4'h6 |-> c2.neg == 4'h7 && c3.neg == 4'h8;
  endproperty
  a_neg_lp10: assert property (p_neg_lp10)
    else $error("bad negative set 2");
  property p_rdata;
    s_axi_rvalid |-> (s_axi_rdata & 32'hfffff8f8) == 32'h0;
  endproperty
  a_rdata: assert property (p_rdata)
    else $error("unimplemented bits read nonzero");
  c_neg10: cover property (c1.neg == 4'h6);
  c_neg11: cover property (v == 2'h1 && c1.neg == 4'h9);
  c_pos1: cover property (v == 2'h0 && c1.pos == 4'h3);
endmodule : acis_assertions
bind acis_top acis_assertions i_chk (.clk, .rst, .variant_strap,
  .s_axi_rvalid, .s_axi_rdata, .mux_ctrl);
`default_nettype wire

// ==== verification/acis_top_tb.sv ====
/*
  Self-checking bench for acis_top with an AXI4-Lite master and a model.
  Assumes a 125 MHz clock and the mux model beside the design.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b, m) begin n_tests++; if ((a) !== (b)) begin errors++; $display("FAIL %0t %s", $time, m); end end
module acis_top_tb;
  logic clk = 1'b0, rst = 1'b1, samp_b_active = 1'b0;
  logic [1:0] variant_strap = 2'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  wire logic s_axi_arready, s_axi_rvalid, bad;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  acis_pkg::acis_mux_s mux_ctrl;
  int errors = 0, n_tests = 0, seed = 34, sel, sh;
  logic [31:0] rd, wv;
  logic [1:0] rsp;
  acis_top i_dut (.clk, .rst, .variant_strap, .samp_b_active,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .mux_ctrl);
  acis_mux_model i_mux (.clk, .mux(mux_ctrl), .bad);
  always #4 clk = ~clk;
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rdr(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge clk);
  endtask : rdr
  // Expected codes {ch3, ch2, ch1}, each {neg, pos}.
  function automatic logic [23:0] exp_mux(int n, int p, int v);
    logic [11:0] ng, ps;
    ps = p ? (v == 0 ? 12'hff3 : 12'h543) : 12'h210;
    ng = 12'heee;
    if (v == 1 && n == 3) ng = 12'hfa9;
    if (v == 2 && n == 3) ng = 12'hba9;
    if (v == 2 && n == 2) ng = 12'h876;
    return {ng[11:8], ps[11:8], ng[7:4], ps[7:4], ng[3:0], ps[3:0]};
  endfunction : exp_mux
  task automatic stop_test;
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : stop_test
  initial
  begin
    #100000;
    errors++;
    stop_test();
  end
  initial
  begin
    for (int v = 0; v < 3; v++)
    begin
      rst <= 1'b1;
      variant_strap <= v[1:0];
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rdr(8'h00);
      `CHK(rd, 32'h0, "reset value")
      for (int i = 0; i < 8; i++)
      begin
        wv = $random(seed);
        wv[10:8] = 3'(7 - i);
        wv[2:0] = 3'(i);
        sel = wv & 32'h707;
        wr(8'h00, wv);
        rdr(8'h00);
        `CHK(rd, sel, "readback")
        for (int b = 0; b < 2; b++)
        begin
          // Sequencing input passes a synchroniser before the mux.
          samp_b_active <= b[0];
          repeat (6) @(posedge clk);
          sh = b * 8;
          `CHK(mux_ctrl, exp_mux((sel >> (sh + 1)) & 3, (sel >> sh) & 1, v), "mux")
        end
      end
      wr(8'h04, 32'h3);
      `CHK(rsp, acis_pkg::RESP_SLVERR, "read-only write")
      rdr(8'h04);
      `CHK(rd, v, "variant readback")
      wr(8'h40, 32'h0);
      `CHK(rsp, acis_pkg::RESP_SLVERR, "unmapped write")
      rdr(8'h40);
      `CHK({rsp, rd}, {acis_pkg::RESP_SLVERR, 32'h0}, "unmapped")
      rdr(8'h00);
      `CHK(rd, sel, "register kept")
      s_axi_wstrb <= 4'h2;
      wr(8'h00, 32'h0);
      s_axi_wstrb <= 4'hf;
      rdr(8'h00);
      `CHK(rd, sel & 32'h7, "byte strobe")
      $display("variant %0d done", v);
    end
    `CHK(bad, 1'b0, "illegal mux code")
    stop_test();
  end
endmodule : acis_top_tb
`default_nettype wire
